// >>> rtl/bwu_config_slice.sv
// Window upper-address registers, capability pointer and bridge control
`timescale 1ns/1ns
module bwu_config_slice (
    input  wire logic        sys_clk_in,
    input  wire logic        reset_in,
    // Configuration access
    input  wire logic        cfg_wr_in,
    input  wire logic        cfg_rd_in,
    input  wire logic [7:0]  cfg_addr_in,
    input  wire logic [3:0]  cfg_be_in,
    input  wire logic [31:0] cfg_wdata_in,
    output logic [31:0]      cfg_rdata_out,
    output logic             cfg_rvalid_out,
    // Lower window bounds held elsewhere
    input  wire logic [11:0] pref_base_low_in,
    input  wire logic [11:0] pref_limit_low_in,
    input  wire logic [3:0]  io_base_low_in,
    input  wire logic [3:0]  io_limit_low_in,
    // Primary memory and I/O decode
    input  wire logic        mem_valid_in,
    input  wire logic [63:0] mem_addr_in,
    output logic             pref_fwd_down_out,
    input  wire logic        io_valid_in,
    input  wire logic [31:0] io_addr_in,
    output logic             io_fwd_down_out,
    // Secondary I/O decode
    input  wire logic        sec_io_valid_in,
    input  wire logic [31:0] sec_io_addr_in,
    output logic             io_fwd_up_out,
    // Secondary error handling
    input  wire logic        sec_parity_err_in,
    output logic             sec_parity_report_out,
    input  wire logic        first_downstream_syserr_pin_n_in,
    input  wire logic        second_downstream_syserr_pin_n_in,
    output logic             pri_syserr_req_out
);
    logic [31:0] pref_bot_hi_q;
    logic [31:0] pref_top_hi_q;
    logic [31:0] io_hi_q;
    logic [2:0]  ctrl_q;
    logic [31:0] rdata_d;
    logic [31:0] rdata_q;
    logic        rvalid_q;
    logic        pref_fwd_q;
    logic        io_down_q;
    logic        io_up_q;
    logic        parity_q;
    logic        serr_q;
    logic        sel_bot;
    logic        sel_top;
    logic        sel_io;
    logic        sel_ctrl;
    logic [63:0] pref_bottom;
    logic [63:0] pref_top;
    logic [31:0] io_bottom;
    logic [31:0] io_top;
    logic        pref_hit;
    logic        io_hit;
    logic        isa_on;
    logic        down_alias;
    logic        up_alias;

    // Dword decode of the configuration offset
    assign sel_bot  = cfg_addr_in[7:2] == bwu_pkg::OFS_PREF_BOT_HI[7:2];
    assign sel_top  = cfg_addr_in[7:2] == bwu_pkg::OFS_PREF_TOP_HI[7:2];
    assign sel_io   = cfg_addr_in[7:2] == bwu_pkg::OFS_IO_HI[7:2];
    assign sel_ctrl = cfg_addr_in[7:2] == bwu_pkg::OFS_BRIDGE_CTRL[7:2];

    // Byte-lane writes of the window upper halves
    for (genvar i = 0; i < 4; i++) begin : g_lane
        always_ff @(posedge sys_clk_in or posedge reset_in) begin
            if (reset_in) begin
                pref_bot_hi_q[8*i +: 8] <= bwu_pkg::REG_RESET[8*i+:8];
                pref_top_hi_q[8*i +: 8] <= bwu_pkg::REG_RESET[8*i+:8];
                io_hi_q[8*i +: 8]       <= bwu_pkg::REG_RESET[8*i+:8];
            end else if (cfg_wr_in && cfg_be_in[i]) begin
                if (sel_bot) begin
                    pref_bot_hi_q[8*i +: 8] <= cfg_wdata_in[8*i +: 8];
                end
                if (sel_top) begin
                    pref_top_hi_q[8*i +: 8] <= cfg_wdata_in[8*i +: 8];
                end
                if (sel_io) begin
                    io_hi_q[8*i +: 8] <= cfg_wdata_in[8*i +: 8];
                end
            end
        end
    end

    // Bridge control bits 18:16 in byte lane 2
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            ctrl_q <= bwu_pkg::CTRL_RESET;
        end else if (cfg_wr_in && sel_ctrl
                     && cfg_be_in[bwu_pkg::CTRL_LANE]) begin
            ctrl_q <= cfg_wdata_in[bwu_pkg::CTRL_LSB +: 3];
        end
    end

    // Read data mux; unmapped offsets read zero
    always_comb begin
        rdata_d = bwu_pkg::REG_RESET;
        case (cfg_addr_in[7:2])
            bwu_pkg::OFS_PREF_LOW[7:2]: begin
                rdata_d = {pref_limit_low_in, bwu_pkg::PREF_64BIT_CODE,
                           pref_base_low_in, bwu_pkg::PREF_64BIT_CODE};
            end
            bwu_pkg::OFS_PREF_BOT_HI[7:2]: rdata_d = pref_bot_hi_q;
            bwu_pkg::OFS_PREF_TOP_HI[7:2]: rdata_d = pref_top_hi_q;
            bwu_pkg::OFS_IO_HI[7:2]:       rdata_d = io_hi_q;
            bwu_pkg::OFS_CAP_PTR[7:2]: begin
                rdata_d[7:0] = bwu_pkg::CAP_LIST_PTR;
            end
            bwu_pkg::OFS_BRIDGE_CTRL[7:2]: begin
                rdata_d[bwu_pkg::CTRL_LSB +: 3] = ctrl_q;
            end
            default: rdata_d = bwu_pkg::REG_RESET;
        endcase
    end

    // Registered read answer, one cycle after the read strobe
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            rdata_q  <= bwu_pkg::REG_RESET;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= cfg_rd_in;
            if (cfg_rd_in) begin
                rdata_q <= rdata_d;
            end
        end
    end

    assign cfg_rdata_out  = rdata_q;
    assign cfg_rvalid_out = rvalid_q;

    // Full window bounds from upper and lower parts
    assign pref_bottom = {pref_bot_hi_q, pref_base_low_in,
                          bwu_pkg::PREF_BOT_FILL};
    assign pref_top    = {pref_top_hi_q, pref_limit_low_in,
                          bwu_pkg::PREF_TOP_FILL};
    assign io_bottom   = {io_hi_q[15:0], io_base_low_in,
                          bwu_pkg::IO_BOT_FILL};
    assign io_top      = {io_hi_q[31:16], io_limit_low_in,
                          bwu_pkg::IO_TOP_FILL};

    bwu_window_cmp #(.W(64)) u_pref_cmp (
        .addr_in   (mem_addr_in),
        .bottom_in (pref_bottom),
        .top_in    (pref_top),
        .hit_out   (pref_hit)
    );

    bwu_window_cmp #(.W(32)) u_io_cmp (
        .addr_in   (io_addr_in),
        .bottom_in (io_bottom),
        .top_in    (io_top),
        .hit_out   (io_hit)
    );

    // ISA alias detection for both directions
    assign isa_on     = ctrl_q[bwu_pkg::CTRL_ISA_BIT];
    assign down_alias = (io_addr_in[31:16] == bwu_pkg::ISA_SPACE_HI)
                        && (io_addr_in[9:8] != bwu_pkg::ISA_KEEP_QUARTER);
    assign up_alias   = sec_io_addr_in[9:8] != bwu_pkg::ISA_KEEP_QUARTER;

    // Forwarding decisions, registered
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            pref_fwd_q <= 1'b0;
            io_down_q  <= 1'b0;
            io_up_q    <= 1'b0;
        end else begin
            pref_fwd_q <= mem_valid_in && pref_hit;
            io_down_q  <= io_valid_in && io_hit
                          && !(isa_on && down_alias);
            io_up_q    <= sec_io_valid_in && (isa_on && up_alias
                          || !io_window_has(sec_io_addr_in));
        end
    end

    // Secondary-to-primary upstream: outside the downstream I/O window, or an ISA alias while the ISA bit is set
    function automatic logic io_window_has(input logic [31:0] a);
        return (a >= io_bottom) && (a <= io_top);
    endfunction

    assign pref_fwd_down_out = pref_fwd_q;
    assign io_fwd_down_out   = io_down_q;
    assign io_fwd_up_out     = io_up_q;

    // Parity reporting and system error forwarding gates
    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            parity_q <= 1'b0;
            serr_q   <= 1'b0;
        end else begin
            parity_q <= sec_parity_err_in
                        && ctrl_q[bwu_pkg::CTRL_PARITY_BIT];
            serr_q   <= ctrl_q[bwu_pkg::CTRL_SERR_BIT]
                        && (!first_downstream_syserr_pin_n_in
                        || !second_downstream_syserr_pin_n_in);
        end
    end

    assign sec_parity_report_out = parity_q;
    assign pri_syserr_req_out    = serr_q;

    // Checks
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (reset_in);

    sequence s_full_write(logic [7:0] ofs);
        cfg_wr_in && cfg_be_in == 4'hf && cfg_addr_in == ofs;
    endsequence

    sequence s_read(logic [7:0] ofs);
        cfg_rd_in && !cfg_wr_in && cfg_addr_in == ofs;
    endsequence

    chk_bot_readback: assert property (
        s_full_write(bwu_pkg::OFS_PREF_BOT_HI) ##1
        s_read(bwu_pkg::OFS_PREF_BOT_HI)
        |=> cfg_rvalid_out && cfg_rdata_out == $past(cfg_wdata_in, 2))
        else $error("prefetch bottom upper readback wrong");

    chk_top_readback: assert property (
        s_full_write(bwu_pkg::OFS_PREF_TOP_HI) ##1
        s_read(bwu_pkg::OFS_PREF_TOP_HI)
        |=> cfg_rdata_out == $past(cfg_wdata_in, 2))
        else $error("prefetch top upper readback wrong");

    chk_io_bot_field: assert property (
        s_full_write(bwu_pkg::OFS_IO_HI) ##1 s_read(bwu_pkg::OFS_IO_HI)
        |=> cfg_rdata_out[15:0] == $past(cfg_wdata_in[15:0], 2))
        else $error("I/O bottom upper field readback wrong");

    chk_io_top_field: assert property (
        s_full_write(bwu_pkg::OFS_IO_HI) ##1 s_read(bwu_pkg::OFS_IO_HI)
        |=> cfg_rdata_out[31:16] == $past(cfg_wdata_in[31:16], 2))
        else $error("I/O top upper field readback wrong");

    chk_cap_ptr_const: assert property (
        s_read(bwu_pkg::OFS_CAP_PTR)
        |=> cfg_rdata_out == 32'h0000_00b0)
        else $error("capability pointer not b0");

    chk_pref_code: assert property (
        s_read(bwu_pkg::OFS_PREF_LOW)
        |=> cfg_rdata_out[3:0] == 4'h1 && cfg_rdata_out[19:16] == 4'h1)
        else $error("prefetch 64-bit code wrong");

    chk_parity_gate: assert property (
        sec_parity_err_in |=> sec_parity_report_out == $past(ctrl_q[0]))
        else $error("parity report gating wrong");

    chk_serr_gate: assert property (
        !ctrl_q[1] |=> !pri_syserr_req_out)
        else $error("system error forwarded while disabled");

    chk_isa_off_fwd: assert property (
        io_valid_in && io_hit && !isa_on |=> io_fwd_down_out)
        else $error("in-window I/O not forwarded");

    chk_isa_block: assert property (
        io_valid_in && isa_on && io_addr_in[31:16] == 16'h0000
        && io_addr_in[9:8] != 2'h0 |=> !io_fwd_down_out)
        else $error("ISA alias forwarded downstream");

    chk_isa_up: assert property (
        sec_io_valid_in && isa_on && sec_io_addr_in[9:8] != 2'h0
        |=> io_fwd_up_out)
        else $error("ISA alias not forwarded upstream");

    chk_pref_bounds: assert property (
        mem_valid_in && (mem_addr_in == pref_bottom || mem_addr_in ==
        pref_top) && pref_bottom <= pref_top |=> pref_fwd_down_out)
        else $error("prefetch window edge not forwarded");

    chk_io_bounds: assert property (
        io_valid_in && !isa_on && io_bottom <= io_top
        && io_addr_in == {io_hi_q[31:16], io_limit_low_in, 12'hfff}
        |=> io_fwd_down_out)
        else $error("I/O top bound not formed from both parts");
endmodule

// >>> rtl/bwu_pkg.sv
// Constants for the bridge window upper-address and control slice
package bwu_pkg;
    // Configuration byte offsets
    localparam logic [7:0]  OFS_PREF_LOW     = 8'h24;
    localparam logic [7:0]  OFS_PREF_BOT_HI  = 8'h28;
    localparam logic [7:0]  OFS_PREF_TOP_HI  = 8'h2c;
    localparam logic [7:0]  OFS_IO_HI        = 8'h30;
    localparam logic [7:0]  OFS_CAP_PTR      = 8'h34;
    localparam logic [7:0]  OFS_BRIDGE_CTRL  = 8'h3c;
    // Reset and constant read values
    localparam logic [31:0] REG_RESET        = 32'h0000_0000;
    localparam logic [7:0]  CAP_LIST_PTR     = 8'hb0;
    localparam logic [3:0]  PREF_64BIT_CODE  = 4'h1;
    localparam logic [2:0]  CTRL_RESET       = 3'h0;
    // Bridge control field positions
    localparam int          CTRL_LSB         = 16;
    localparam int          CTRL_PARITY_BIT  = 0;
    localparam int          CTRL_SERR_BIT    = 1;
    localparam int          CTRL_ISA_BIT     = 2;
    localparam int          CTRL_LANE        = 2;
    // Implied low address bits of window bounds
    localparam logic [19:0] PREF_BOT_FILL    = 20'h00000;
    localparam logic [19:0] PREF_TOP_FILL    = 20'hfffff;
    localparam logic [11:0] IO_BOT_FILL      = 12'h000;
    localparam logic [11:0] IO_TOP_FILL      = 12'hfff;
    // ISA alias: offsets 100h..3ffh of each 1KB block; first 64KB only for downstream, any address upstream
    localparam logic [15:0] ISA_SPACE_HI     = 16'h0000;
    localparam logic [1:0]  ISA_KEEP_QUARTER = 2'h0;
endpackage

// >>> rtl/bwu_window_cmp.sv
// Inclusive address window comparator
`timescale 1ns/1ns
module bwu_window_cmp #(
    parameter int W = 64
) (
    input  wire logic [W-1:0] addr_in,
    input  wire logic [W-1:0] bottom_in,
    input  wire logic [W-1:0] top_in,
    output logic              hit_out
);
    // Both ends of the window count as inside
    assign hit_out = (addr_in >= bottom_in) && (addr_in <= top_in);
endmodule

// >>> bench/bwu_sec_agent.sv
// Secondary-side agent model: I/O requests, error pins, parity flag
`timescale 1ns/1ns
module bwu_sec_agent (
    input  wire logic        sys_clk_in,
    input  wire logic        req_in,
    input  wire logic [31:0] addr_in,
    input  wire logic [1:0]  serr_in,
    input  wire logic        perr_in,
    output logic             sec_io_valid_out,
    output logic [31:0]      sec_io_addr_out,
    output logic             first_syserr_n_out,
    output logic             second_syserr_n_out,
    output logic             parity_err_out
);
    logic [31:0] last_q = 32'h0000_0000;
    // Remember the last address driven
    always_ff @(posedge sys_clk_in) begin
        if (req_in) last_q <= addr_in;
    end
    // Idle bus shows the inverse of the last address; error lines pulled up
    always_comb begin
        sec_io_valid_out    = req_in;
        sec_io_addr_out     = req_in ? addr_in : ~last_q;
        first_syserr_n_out  = ~serr_in[0];
        second_syserr_n_out = ~serr_in[1];
        parity_err_out      = perr_in;
    end
endmodule

// >>> bench/tb_bwu_config_slice.sv
// Self-checking bench for the window upper-address and control slice
`timescale 1ns/1ns
module tb_bwu_config_slice;
    logic        clk = 0, rst = 1, wr = 0, rd = 0, rvalid, pfd, iod, iou;
    logic        mv = 0, iv = 0, sreq = 0, perr = 0, s_v, s1n, s2n, s_pe;
    logic        prep, psys;
    logic [1:0]  serr = 0;
    logic [2:0]  ctl = 0;
    logic [3:0]  be = 0, iobl = 0, iol = 0;
    logic [7:0]  addr = 0;
    logic [11:0] pbl = 0, pll = 0;
    logic [31:0] wdata = 0, rdata, iaddr = 0, saddr = 0, s_a;
    logic [31:0] bot = 0, top = 0, io = 0;
    logic [63:0] maddr = 0;
    logic [7:0]  ofs [7] = '{8'h24, 8'h28, 8'h2c, 8'h30, 8'h34, 8'h3c, 8'h38};
    logic [31:0] isa [6] = '{32'h0ff, 32'h100, 32'h3ff, 32'h400, 32'h4ff,
                             32'h10100};
    int          n_errors = 0, check_count = 0, cyc = 0;

    bwu_config_slice bwu_config_slice_inst (
        .sys_clk_in(clk), .reset_in(rst), .cfg_wr_in(wr), .cfg_rd_in(rd),
        .cfg_addr_in(addr), .cfg_be_in(be), .cfg_wdata_in(wdata),
        .cfg_rdata_out(rdata), .cfg_rvalid_out(rvalid),
        .pref_base_low_in(pbl), .pref_limit_low_in(pll),
        .io_base_low_in(iobl), .io_limit_low_in(iol),
        .mem_valid_in(mv), .mem_addr_in(maddr), .pref_fwd_down_out(pfd),
        .io_valid_in(iv), .io_addr_in(iaddr), .io_fwd_down_out(iod),
        .sec_io_valid_in(s_v), .sec_io_addr_in(s_a), .io_fwd_up_out(iou),
        .sec_parity_err_in(s_pe), .sec_parity_report_out(prep),
        .first_downstream_syserr_pin_n_in(s1n),
        .second_downstream_syserr_pin_n_in(s2n),
        .pri_syserr_req_out(psys));

    bwu_sec_agent bwu_sec_agent_inst (
        .sys_clk_in(clk), .req_in(sreq), .addr_in(saddr), .serr_in(serr),
        .perr_in(perr), .sec_io_valid_out(s_v), .sec_io_addr_out(s_a),
        .first_syserr_n_out(s1n), .second_syserr_n_out(s2n),
        .parity_err_out(s_pe));

    // Clock generator
    initial forever #2 clk = ~clk;

    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            n_errors++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Expected read value from the register model
    function automatic logic [31:0] exp_rd(input logic [7:0] a);
        case (a & 8'hfc)
            8'h24: return {pll, 4'h1, pbl, 4'h1};
            8'h28: return bot;
            8'h2c: return top;
            8'h30: return io;
            8'h34: return 32'h0000_00b0;
            8'h3c: return {13'h0, ctl, 16'h0};
            default: return 32'h0;
        endcase
    endfunction

    function automatic logic io_hit(input logic [31:0] a);
        return a >= {io[15:0], iobl, 12'h0} && a <= {io[31:16], iol, 12'hfff};
    endfunction

    // Window edges, one past them, or a random address with bits 31:16 clear
    function automatic logic [63:0] pick(input logic [63:0] lo, hi);
        case ($urandom_range(4))
            0: return lo;
            1: return lo - 64'h1;
            2: return hi;
            3: return hi + 64'h1;
            default: return {32'($urandom), 16'h0, 16'($urandom)};
        endcase
    endfunction

    // Register write, driven at the current edge, taken at the next
    task automatic cfg_wr(input logic [7:0] a, input logic [3:0] b,
                          input logic [31:0] d);
        wr <= 1'b1;
        addr <= a;
        be <= b;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (b[i] && a[7:2] == 6'h0a) bot[8*i+:8] = d[8*i+:8];
            if (b[i] && a[7:2] == 6'h0b) top[8*i+:8] = d[8*i+:8];
            if (b[i] && a[7:2] == 6'h0c) io[8*i+:8] = d[8*i+:8];
        end
        if (b[2] && a[7:2] == 6'h0f) ctl = d[18:16];
    endtask

    // Register read; answer looked at mid-cycle while rvalid stands
    task automatic cfg_rd(input logic [7:0] a);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        chk(rvalid, 1'b1);
        chk(rdata, exp_rd(a));
        @(posedge clk);
    endtask

    // One decode cycle on all request paths, outputs checked next cycle
    task automatic dec(input logic [63:0] ma, input logic [31:0] ia, sa,
                       input logic m, i, s, input logic [1:0] se,
                       input logic pe);
        logic ep, ed, eu;
        mv <= m;
        maddr <= ma;
        iv <= i;
        iaddr <= ia;
        sreq <= s;
        saddr <= sa;
        serr <= se;
        perr <= pe;
        @(posedge clk);
        mv <= 1'b0;
        iv <= 1'b0;
        sreq <= 1'b0;
        serr <= 2'h0;
        perr <= 1'b0;
        ep = m && ma >= {bot, pbl, 20'h0} && ma <= {top, pll, 20'hfffff};
        ed = i && io_hit(ia)
             && !(ctl[2] && ia[31:16] == 16'h0 && ia[9:8] != 2'h0);
        eu = s && ((ctl[2] && sa[9:8] != 2'h0) || !io_hit(sa));
        @(negedge clk);
        chk(pfd, ep);
        chk(iod, ed);
        chk(iou, eu);
        chk(prep, pe & ctl[0]);
        chk(psys, ctl[1] && se != 2'h0);
        @(posedge clk);
    endtask

    // Main sequence
    initial begin
        logic [63:0] ma, t, u;
        logic [31:0] d;
        logic [7:0]  a;
        void'($urandom(32'h0f14));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        foreach (ofs[k]) cfg_rd(ofs[k]);
        $display("test reset values done");
        // Full-word writes read back in the very next cycle
        for (int k = 1; k < 4; k++) begin
            d = $urandom;
            cfg_wr(ofs[k], 4'hf, d);
            cfg_rd(ofs[k]);
        end
        cfg_wr(8'h30, 4'hf, 32'h0);
        cfg_rd(8'h30);
        $display("test full write readback done");
        iol <= 4'hf;
        for (int c = 0; c < 2; c++) begin
            cfg_wr(8'h3c, 4'hf, c ? 32'hffff_ffff : 32'h0);
            cfg_rd(8'h3c);
            cfg_wr(8'h34, 4'hf, 32'hffff_ffff);
            cfg_rd(8'h34);
            foreach (isa[k]) dec(64'h0, isa[k], isa[k], 1'b0, 1'b1, 1'b1,
                                 2'(k), 1'(k));
        end
        $display("test isa and error gating done");
        for (int n = 0; n < 60; n++) begin
            a = ofs[$urandom_range(6)] | 8'($urandom_range(3));
            d = $urandom;
            if ($urandom_range(1)) d = d & 32'h0003_0003;
            @(posedge clk);
            pbl <= 12'($urandom); pll <= 12'($urandom);
            iobl <= 4'($urandom); iol <= 4'($urandom);
            cfg_wr(a, 4'($urandom), d);
            cfg_rd(a);
            for (int k = 0; k < 4; k++) begin
                ma = pick({bot, pbl, 20'h0}, {top, pll, 20'hfffff});
                t = pick({32'h0, io[15:0], iobl, 12'h0},
                         {32'h0, io[31:16], iol, 12'hfff});
                u = pick({32'h0, io[15:0], iobl, 12'h0},
                         {32'h0, io[31:16], iol, 12'hfff});
                dec(ma, t[31:0], u[31:0], 1'($urandom), 1'($urandom),
                    1'($urandom), 2'($urandom), 1'($urandom));
            end
        end
        $display("test random access and decode done");
        // Reset in mid-run clears every writable field
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        bot = 32'h0;
        top = 32'h0;
        io = 32'h0;
        ctl = 3'h0;
        foreach (ofs[k]) cfg_rd(ofs[k]);
        $display("test mid-run reset done");
        end_of_test();
    end
endmodule
